// >>> core/smc_defines.svh
`ifndef SMC_DEFINES_SVH
`define SMC_DEFINES_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define SMC_OFS_SYS_CLK_CTRL 8'h00
`define SMC_OFS_HS_OSC_CTRL 8'h04
`define SMC_OFS_MODE_STATUS 8'h08

// ----------------------------------------
// field positions
// ----------------------------------------
`define SMC_SEL_MSB 7
`define SMC_SEL_LSB 5
`define SMC_HS_IDLE_BIT 1
`define SMC_LS_IDLE_BIT 0
`define SMC_HS_FLAG_BIT 1
`define SMC_HS_EN_BIT 0
`define SMC_ST_PWRDN_BIT 0
`define SMC_ST_TMOUT_BIT 1
`define SMC_ST_BUSY_BIT 2
`define SMC_ST_LSRDY_BIT 3
`define SMC_ST_MODE_LSB 4

// ----------------------------------------
// reset values and codes
// ----------------------------------------
`define SMC_SEL_RST 3'h0
`define SMC_SEL_SUB 3'h7
`define SMC_HS_EN_RST 1'h1

// ----------------------------------------
// timing
// ----------------------------------------
`define SMC_CORE_PERIOD_NS 20
`define SMC_HS_PERIOD_NS 125
`define SMC_LS_PERIOD_NS 31250
`define SMC_HS_CYC ((`SMC_HS_PERIOD_NS + `SMC_CORE_PERIOD_NS - 1) / `SMC_CORE_PERIOD_NS)
`define SMC_LS_CYC ((`SMC_LS_PERIOD_NS + `SMC_CORE_PERIOD_NS - 1) / `SMC_CORE_PERIOD_NS)

`endif

// >>> core/smc_pkg.sv
package smc_pkg;
	typedef enum logic [2:0] {
		SMC_FAST = 3'b000,
		SMC_SLOW = 3'b001,
		SMC_SLEEP = 3'b010,
		SMC_IDLE0 = 3'b011,
		SMC_IDLE1 = 3'b100,
		SMC_IDLE2 = 3'b101
	} smc_mode_e;
	typedef logic [2:0] smc_sel_t;
	typedef logic [15:0] smc_cnt_t;
endpackage : smc_pkg

// >>> core/smc_top.sv
// The AHB-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "smc_defines.svh"
// Overview of operation
// - select field picks divided fast or slow clock
// - halt with both idle bits low enters sleep
// - halt with fast low, slow high: idle0
// - halt with both idle bits high: idle1
// - halt with fast high, slow low: idle2
// - halt sets power-down flag, clears timeout flag unless a timeout comes in the same cycle
// - halt clears the watchdog counter
// - halted modes hold execution and all state
// - enabling fast oscillator clears, then sets stable flag
// - fast oscillator enable at bit 0, resets high
// - slow mode fast clock follows enable bit
// - clock switch waits the documented switch delay
// - switch to slow waits for slow oscillator
// - unimplemented control bits read as zero
// - sleep keeps watchdog clock only if enabled
// - select switches run modes, only halt stops
// - select and idle bits reset to zero
// - fast source 8MHz rc, slow 32kHz rc
// - fast oscillator on slow switch follows enable
module smc_top #(
	parameter int HS_CYC = `SMC_HS_CYC,
	parameter int LS_CYC = `SMC_LS_CYC
) (
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic RESET_N,
	// ahb-lite slave
	input wire logic HSEL,
	input wire logic [7:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic HREADYOUT,
	output logic [31:0] HRDATA,
	output logic HRESP,
	// cpu and watchdog events
	input wire logic HALT_EXEC,
	input wire logic WAKE_REQ,
	input wire logic CLR_WDT_EXEC,
	input wire logic WDT_TIMEOUT,
	input wire logic WDT_ENABLE,
	// oscillator status pins
	input wire logic HS_OSC_READY,
	input wire logic LS_OSC_READY,
	// clock controls
	output smc_pkg::smc_sel_t SYS_CLK_SEL,
	output logic CPU_RUN,
	output logic HOLD_STATE,
	output logic HS_OSC_ON,
	output logic SUB_CLK_ON,
	output logic LOW_SPEED_RC_OSC_ON,
	// status to the core
	output logic POWER_DOWN_FLAG,
	output logic WDT_TIMEOUT_FLAG,
	output logic WDT_CNT_CLR
);
	import smc_pkg::*;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic smc_cnt_t src_period(input smc_sel_t sel);
		src_period = (sel == `SMC_SEL_SUB) ? smc_cnt_t'(LS_CYC) : smc_cnt_t'(HS_CYC);
	endfunction : src_period
	function automatic smc_cnt_t sys_period(input smc_sel_t sel);
		sys_period = (sel == `SMC_SEL_SUB) ? smc_cnt_t'(LS_CYC) :
			smc_cnt_t'(HS_CYC << sel);
	endfunction : sys_period
	// worst case of the switch window, rounded up
	function automatic smc_cnt_t switch_cycles(input smc_sel_t cur, input smc_sel_t tar);
		smc_cnt_t s;
		s = smc_cnt_t'(4 * sys_period(cur));
		s = s + smc_cnt_t'((3 * src_period(cur) + 1) / 2);
		switch_cycles = s + smc_cnt_t'((sys_period(tar) + 1) / 2);
	endfunction : switch_cycles

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [2:0] hs_rdy_sync_ff;
	logic [2:0] ls_rdy_sync_ff;
	logic hs_rdy_ff;
	logic ls_rdy_ff;

	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N) begin
			hs_rdy_sync_ff <= 3'h0;
			ls_rdy_sync_ff <= 3'h0;
			hs_rdy_ff <= 1'h0;
			ls_rdy_ff <= 1'h0;
		end else begin
			hs_rdy_sync_ff <= {hs_rdy_sync_ff[1:0], HS_OSC_READY};
			ls_rdy_sync_ff <= {ls_rdy_sync_ff[1:0], LS_OSC_READY};
			if (hs_rdy_sync_ff[1] == hs_rdy_sync_ff[2]) begin
				hs_rdy_ff <= hs_rdy_sync_ff[2];
			end
			if (ls_rdy_sync_ff[1] == ls_rdy_sync_ff[2]) begin
				ls_rdy_ff <= ls_rdy_sync_ff[2];
			end
		end
	end

	// ----------------------------------------
	// ahb-lite address phase
	// ----------------------------------------
	logic wr_pend_ff;
	logic [7:0] wr_addr_ff;
	logic rd_take;

	assign rd_take = HSEL && HTRANS[1] && HREADY && !HWRITE;

	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N) begin
			wr_pend_ff <= 1'h0;
			wr_addr_ff <= 8'h00;
			HREADYOUT <= 1'h1;
			HRESP <= 1'h0;
		end else begin
			// zero wait states, always okay
			HREADYOUT <= 1'h1;
			HRESP <= 1'h0;
			if (HREADY) begin
				wr_pend_ff <= HSEL && HTRANS[1] && HWRITE;
				wr_addr_ff <= HADDR;
			end
		end
	end

	// ----------------------------------------
	// software registers
	// ----------------------------------------
	smc_sel_t sel_ff;
	logic hs_idle_ff;
	logic ls_idle_ff;
	logic hs_en_ff;
	smc_sel_t nxt_sel;
	logic nxt_hs_idle;
	logic nxt_ls_idle;
	logic nxt_hs_en;
	logic wr_clk_ctrl;
	logic wr_osc_ctrl;

	assign wr_clk_ctrl = wr_pend_ff && (wr_addr_ff == `SMC_OFS_SYS_CLK_CTRL);
	assign wr_osc_ctrl = wr_pend_ff && (wr_addr_ff == `SMC_OFS_HS_OSC_CTRL);

	always_comb begin
		nxt_sel = sel_ff;
		nxt_hs_idle = hs_idle_ff;
		nxt_ls_idle = ls_idle_ff;
		nxt_hs_en = hs_en_ff;
		if (wr_clk_ctrl) begin
			nxt_sel = HWDATA[`SMC_SEL_MSB:`SMC_SEL_LSB];
			nxt_hs_idle = HWDATA[`SMC_HS_IDLE_BIT];
			nxt_ls_idle = HWDATA[`SMC_LS_IDLE_BIT];
		end
		if (wr_osc_ctrl) begin
			nxt_hs_en = HWDATA[`SMC_HS_EN_BIT];
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N) begin
			sel_ff <= `SMC_SEL_RST;
			hs_idle_ff <= 1'h0;
			ls_idle_ff <= 1'h0;
			hs_en_ff <= `SMC_HS_EN_RST;
		end else begin
			sel_ff <= nxt_sel;
			hs_idle_ff <= nxt_hs_idle;
			ls_idle_ff <= nxt_ls_idle;
			hs_en_ff <= nxt_hs_en;
		end
	end

	// ----------------------------------------
	// clock switch sequencing
	// ----------------------------------------
	smc_sel_t act_sel_ff;
	smc_cnt_t sw_cnt_ff;
	logic sw_busy;
	assign sw_busy = (act_sel_ff != sel_ff);

	// a new select restarts the window from the clock now running
	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N) begin
			act_sel_ff <= `SMC_SEL_RST;
			sw_cnt_ff <= 16'h0000;
		end else if (nxt_sel != sel_ff) begin
			sw_cnt_ff <= switch_cycles(act_sel_ff, nxt_sel);
		end else if (sw_busy) begin
			if (sw_cnt_ff != 16'h0000) begin
				sw_cnt_ff <= sw_cnt_ff - 16'h0001;
			end else if (sel_ff != `SMC_SEL_SUB || ls_rdy_ff) begin
				act_sel_ff <= sel_ff;
			end
		end
	end

	// ----------------------------------------
	// operating mode
	// ----------------------------------------
	smc_mode_e mode_ff;
	smc_mode_e run_mode;
	smc_mode_e halt_mode;
	logic running;
	logic halt_go;
	assign running = (mode_ff == SMC_FAST) || (mode_ff == SMC_SLOW);
	assign halt_go = running && HALT_EXEC;
	assign run_mode = (act_sel_ff == `SMC_SEL_SUB) ? SMC_SLOW : SMC_FAST;

	always_comb begin
		unique case ({hs_idle_ff, ls_idle_ff})
			2'b00: halt_mode = SMC_SLEEP;
			2'b01: halt_mode = SMC_IDLE0;
			2'b11: halt_mode = SMC_IDLE1;
			2'b10: halt_mode = SMC_IDLE2;
		endcase
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N) begin
			mode_ff <= SMC_FAST;
		end else if (halt_go) begin
			mode_ff <= halt_mode;
		end else if (running) begin
			mode_ff <= run_mode;
		end else if (WAKE_REQ) begin
			mode_ff <= run_mode;
		end
	end

	// ----------------------------------------
	// fast oscillator stable flag
	// ----------------------------------------
	logic hs_flag_ff;
	logic hs_on_req;

	// oscillator demand per mode, fast source forced on when selected
	always_comb begin
		unique case (mode_ff)
			SMC_FAST: hs_on_req = 1'h1;
			SMC_SLOW: hs_on_req = hs_en_ff;
			SMC_IDLE1, SMC_IDLE2: hs_on_req = 1'h1;
			default: hs_on_req = 1'h0;
		endcase
	end

	// ready pin lags the enable, so the rising write blanks the flag
	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N) begin
			hs_flag_ff <= 1'h0;
		end else if (nxt_hs_en && !hs_en_ff) begin
			hs_flag_ff <= 1'h0;
		end else if (!hs_on_req || !hs_rdy_ff) begin
			hs_flag_ff <= 1'h0;
		end else begin
			hs_flag_ff <= 1'h1;
		end
	end

	// ----------------------------------------
	// power-down and timeout flags
	// ----------------------------------------
	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N) begin
			POWER_DOWN_FLAG <= 1'h0;
		end else if (halt_go) begin
			POWER_DOWN_FLAG <= 1'h1;
		end else if (CLR_WDT_EXEC) begin
			POWER_DOWN_FLAG <= 1'h0;
		end
	end

	// a timeout in the halt cycle still lands
	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N) begin
			WDT_TIMEOUT_FLAG <= 1'h0;
		end else if (WDT_TIMEOUT) begin
			WDT_TIMEOUT_FLAG <= 1'h1;
		end else if (halt_go || CLR_WDT_EXEC) begin
			WDT_TIMEOUT_FLAG <= 1'h0;
		end
	end

	// ----------------------------------------
	// clock control outputs
	// ----------------------------------------
	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N) begin
			WDT_CNT_CLR <= 1'h0;
			HOLD_STATE <= 1'h0;
			CPU_RUN <= 1'h0;
			SYS_CLK_SEL <= `SMC_SEL_RST;
			HS_OSC_ON <= 1'h1;
			SUB_CLK_ON <= 1'h1;
			LOW_SPEED_RC_OSC_ON <= 1'h1;
		end else begin
			WDT_CNT_CLR <= halt_go;
			HOLD_STATE <= !running;
			// cpu waits for the source it runs from to settle
			CPU_RUN <= running && ((run_mode == SMC_SLOW) ? ls_rdy_ff : hs_flag_ff);
			SYS_CLK_SEL <= act_sel_ff;
			HS_OSC_ON <= hs_on_req;
			SUB_CLK_ON <= (mode_ff != SMC_SLEEP) && (mode_ff != SMC_IDLE2);
			LOW_SPEED_RC_OSC_ON <= (mode_ff != SMC_SLEEP) || WDT_ENABLE;
		end
	end

	// ----------------------------------------
	// read data
	// ----------------------------------------
	logic [31:0] rd_val;
	// built from next values so a read right behind a write sees it
	always_comb begin
		rd_val = 32'h0000_0000;
		unique case (HADDR)
			`SMC_OFS_SYS_CLK_CTRL: begin
				rd_val[`SMC_SEL_MSB:`SMC_SEL_LSB] = nxt_sel;
				rd_val[`SMC_HS_IDLE_BIT] = nxt_hs_idle;
				rd_val[`SMC_LS_IDLE_BIT] = nxt_ls_idle;
			end
			`SMC_OFS_HS_OSC_CTRL: begin
				rd_val[`SMC_HS_FLAG_BIT] = hs_flag_ff;
				rd_val[`SMC_HS_EN_BIT] = nxt_hs_en;
			end
			`SMC_OFS_MODE_STATUS: begin
				rd_val[`SMC_ST_PWRDN_BIT] = POWER_DOWN_FLAG;
				rd_val[`SMC_ST_TMOUT_BIT] = WDT_TIMEOUT_FLAG;
				rd_val[`SMC_ST_BUSY_BIT] = sw_busy;
				rd_val[`SMC_ST_LSRDY_BIT] = ls_rdy_ff;
				rd_val[`SMC_ST_MODE_LSB +: 3] = mode_ff;
			end
			default: rd_val = 32'h0000_0000;
		endcase
	end
	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N) begin
			HRDATA <= 32'h0000_0000;
		end else if (rd_take) begin
			HRDATA <= rd_val;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RESET_N);
	sequence s_halt_bits(logic [1:0] bits);
		halt_go && ({hs_idle_ff, ls_idle_ff} == bits);
	endsequence
	property p_halt_to(logic [1:0] bits, smc_mode_e m);
		s_halt_bits(bits) |=> (mode_ff == m) ##1 HOLD_STATE;
	endproperty
	chk_reset_values: assert property (
		$rose(RESET_N) |-> (sel_ff == 3'h0) && !hs_idle_ff && !ls_idle_ff && hs_en_ff)
		else $error("control bits wrong after reset");
	chk_halt_sleep: assert property (p_halt_to(2'b00, SMC_SLEEP))
		else $error("halt did not enter sleep");
	chk_halt_idle0: assert property (p_halt_to(2'b01, SMC_IDLE0))
		else $error("halt did not enter idle0");
	chk_halt_idle1: assert property (p_halt_to(2'b11, SMC_IDLE1))
		else $error("halt did not enter idle1");
	chk_halt_idle2: assert property (p_halt_to(2'b10, SMC_IDLE2))
		else $error("halt did not enter idle2");
	chk_halt_flags_set: assert property (
		(halt_go && !WDT_TIMEOUT) |=> POWER_DOWN_FLAG && !WDT_TIMEOUT_FLAG)
		else $error("halt flags not updated");
	chk_wdt_clear_pulse: assert property (halt_go |=> WDT_CNT_CLR ##1 !WDT_CNT_CLR)
		else $error("watchdog clear pulse wrong");
	// a select write in the halt is allowed and is left to the write path
	chk_hold_stable: assert property (
		(!running && !WAKE_REQ && !wr_clk_ctrl) |=> $stable(mode_ff) && $stable(sel_ff))
		else $error("halted state moved");
	chk_hs_flag_clear: assert property (
		(wr_osc_ctrl && HWDATA[0] && !hs_en_ff) |=> !hs_flag_ff)
		else $error("stable flag not cleared on enable");
	chk_switch_wait: assert property (
		((nxt_sel != sel_ff) && (nxt_sel != act_sel_ff)) |=>
		sw_busy && (sw_cnt_ff > 16'h0000) ##1 $stable(act_sel_ff))
		else $error("clock switched too early");
	chk_slow_needs_ls: assert property (
		$changed(act_sel_ff) && (act_sel_ff == 3'h7) |-> $past(ls_rdy_ff))
		else $error("slow switch before oscillator stable");
	chk_sleep_ls_rc: assert property (
		(mode_ff == SMC_SLEEP) |=> LOW_SPEED_RC_OSC_ON == $past(WDT_ENABLE))
		else $error("sleep watchdog clock wrong");
	chk_wake_mode: assert property (
		(!running && WAKE_REQ && !halt_go) |=> (mode_ff == $past(run_mode)))
		else $error("wake resumed wrong mode");
endmodule : smc_top

// >>> verification/smc_top_tb.sv
`timescale 1ns/1ps
`include "smc_defines.svh"
module smc_top_tb;
	import smc_pkg::*;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic CORE_CLK, RESET_N, HSEL, HWRITE, HALT_EXEC, WAKE_REQ, CLR_WDT_EXEC;
	logic WDT_TIMEOUT, WDT_ENABLE, HS_OSC_READY, LS_OSC_READY;
	logic [7:0] HADDR;
	logic [1:0] HTRANS;
	logic [2:0] HSIZE;
	logic [31:0] HWDATA, rd;
	wire logic [31:0] HRDATA;
	wire logic HREADYOUT, HRESP, CPU_RUN, HOLD_STATE, HS_OSC_ON, SUB_CLK_ON;
	wire logic POWER_DOWN_FLAG, WDT_TIMEOUT_FLAG, WDT_CNT_CLR, LOW_SPEED_RC_OSC_ON;
	wire smc_sel_t SYS_CLK_SEL;
	logic [1:0] idl [5] = '{2'h0, 2'h0, 2'h1, 2'h3, 2'h2};
	logic [2:0] m;
	int n_errors = 0;
	int checked = 0;
	// small oscillator counts keep the slow switch short
	smc_top #(.HS_CYC(7), .LS_CYC(20)) u_dut (
		.CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .HSEL(HSEL), .HADDR(HADDR),
		.HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
		.HREADY(HREADYOUT), .HREADYOUT(HREADYOUT), .HRDATA(HRDATA), .HRESP(HRESP),
		.HALT_EXEC(HALT_EXEC), .WAKE_REQ(WAKE_REQ), .CLR_WDT_EXEC(CLR_WDT_EXEC),
		.WDT_TIMEOUT(WDT_TIMEOUT), .WDT_ENABLE(WDT_ENABLE), .HS_OSC_READY(HS_OSC_READY),
		.LS_OSC_READY(LS_OSC_READY), .SYS_CLK_SEL(SYS_CLK_SEL), .CPU_RUN(CPU_RUN),
		.HOLD_STATE(HOLD_STATE), .HS_OSC_ON(HS_OSC_ON), .SUB_CLK_ON(SUB_CLK_ON),
		.LOW_SPEED_RC_OSC_ON(LOW_SPEED_RC_OSC_ON), .POWER_DOWN_FLAG(POWER_DOWN_FLAG),
		.WDT_TIMEOUT_FLAG(WDT_TIMEOUT_FLAG), .WDT_CNT_CLR(WDT_CNT_CLR)
	);
	initial begin
		CORE_CLK = 1'b0;
		forever #10 CORE_CLK = ~CORE_CLK;
	end
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic finish_test;
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : finish_test
	task automatic chk(input logic [31:0] exp, input logic [31:0] got, input string msg);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("FAIL %0t %s: got %0h exp %0h", $time, msg, got, exp);
		end
	endtask : chk
	task automatic ready_wait;
		int n;
		n = 0;
		do begin
			@(posedge CORE_CLK);
			n++;
		end while (HREADYOUT !== 1'b1 && n < 50);
		if (HREADYOUT !== 1'b1) begin
			n_errors++;
			$display("FAIL %0t bus hang", $time);
			finish_test();
		end
	endtask : ready_wait
	// one single word transfer; read data lands in rd
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge CORE_CLK);
		HSEL <= 1'b1;
		HTRANS <= 2'h2;
		HADDR <= a;
		HWRITE <= w;
		ready_wait();
		HTRANS <= 2'h0;
		HSEL <= 1'b0;
		HWDATA <= d;
		ready_wait();
		rd = HRDATA;
		chk(32'h0, 32'(HRESP), "okay response");
	endtask : bus
	task automatic pulse(input int k);
		@(posedge CORE_CLK);
		case (k)
			0: HALT_EXEC <= 1'b1;
			1: WAKE_REQ <= 1'b1;
			2: CLR_WDT_EXEC <= 1'b1;
			default: WDT_TIMEOUT <= 1'b1;
		endcase
		@(posedge CORE_CLK);
		{HALT_EXEC, WAKE_REQ, CLR_WDT_EXEC, WDT_TIMEOUT} <= 4'h0;
	endtask : pulse
	task automatic wait_sel(input smc_sel_t s, input int b);
		int n;
		n = 0;
		while (SYS_CLK_SEL !== s && n < b) begin
			@(posedge CORE_CLK);
			n++;
		end
		chk(32'(s), 32'(SYS_CLK_SEL), "select switch");
		// a used-up bound is already counted by the compare above
		if (SYS_CLK_SEL !== s) begin
			finish_test();
		end
	endtask : wait_sel
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{RESET_N, HSEL, HWRITE, HALT_EXEC, WAKE_REQ, CLR_WDT_EXEC} = 6'h00;
		{WDT_TIMEOUT, WDT_ENABLE, HS_OSC_READY, LS_OSC_READY} = 4'h0;
		HADDR = 8'h00;
		HTRANS = 2'h0;
		HSIZE = 3'h2;
		HWDATA = 32'h0;
		repeat (3) @(posedge CORE_CLK);
		RESET_N <= 1'b1;
		bus(1'b0, `SMC_OFS_SYS_CLK_CTRL, 32'h0);
		chk(32'h0, rd, "clock control reset");
		bus(1'b0, `SMC_OFS_HS_OSC_CTRL, 32'h0);
		chk(32'h1, rd, "osc control reset");
		chk(32'(CPU_RUN), 32'h0, "cpu held until stable");
		bus(1'b0, 8'h0C, 32'h0);
		chk(32'h0, rd, "unmapped read");
		HS_OSC_READY <= 1'b1;
		for (int n = 0; n < 20 && CPU_RUN !== 1'b1; n++) @(posedge CORE_CLK);
		chk(32'(CPU_RUN), 32'h1, "cpu runs");
		bus(1'b1, `SMC_OFS_SYS_CLK_CTRL, 32'h1C);
		bus(1'b0, `SMC_OFS_SYS_CLK_CTRL, 32'h0);
		chk(32'h0, rd, "clock control gaps");
		bus(1'b1, `SMC_OFS_HS_OSC_CTRL, 32'hFD);
		bus(1'b0, `SMC_OFS_HS_OSC_CTRL, 32'h0);
		chk(32'h3, rd, "osc control gaps");
		$display("test registers done");
		// every halted mode, sleep with watchdog off and on
		for (int i = 0; i < 5; i++) begin
			m = (idl[i] == 2'h0) ? 3'h2 : (idl[i] == 2'h1) ? 3'h3 : (idl[i] == 2'h3) ? 3'h4 : 3'h5;
			WDT_ENABLE <= (i == 1);
			bus(1'b1, `SMC_OFS_SYS_CLK_CTRL, {30'h0, idl[i]});
			pulse(3);
			#1;
			chk(32'(WDT_TIMEOUT_FLAG), 32'h1, "timeout set");
			pulse(0);
			#1;
			// counter clear pulses on the same edge as the mode change
			chk(32'({POWER_DOWN_FLAG, WDT_TIMEOUT_FLAG, WDT_CNT_CLR}), 32'h5, "flags");
			@(posedge CORE_CLK);
			#1;
			chk(32'({HOLD_STATE, CPU_RUN, WDT_CNT_CLR}), 32'h4, "halt hold");
			chk(32'({HS_OSC_ON, SUB_CLK_ON}), 32'(idl[i]), "halt clocks");
			chk(32'(LOW_SPEED_RC_OSC_ON), (idl[i] == 2'h0) ? 32'(i == 1) : 32'h1, "ls rc");
			@(posedge CORE_CLK);
			#1;
			chk(32'(WDT_CNT_CLR), 32'h0, "clear one cycle");
			bus(1'b0, `SMC_OFS_MODE_STATUS, 32'h0);
			chk(rd & 32'h73, {25'h0, m, 4'h1}, "halt mode");
			bus(1'b0, `SMC_OFS_SYS_CLK_CTRL, 32'h0);
			chk(rd, {30'h0, idl[i]}, "state kept");
			chk(32'(SYS_CLK_SEL), 32'h0, "select kept");
			pulse(1);
			@(posedge CORE_CLK);
			#1;
			chk(32'(HOLD_STATE), 32'h0, "wake");
			for (int n = 0; n < 20 && CPU_RUN !== 1'b1; n++) @(posedge CORE_CLK);
			chk(32'(CPU_RUN), 32'h1, "resume fast");
		end
		pulse(2);
		#1;
		chk(32'h0, 32'({POWER_DOWN_FLAG, WDT_TIMEOUT_FLAG}), "clear watchdog flags");
		$display("test halt modes done");
		// each divide step: 4 sys + 11 + half target, never early
		for (int s = 1; s < 7; s++) begin
			bus(1'b1, `SMC_OFS_SYS_CLK_CTRL, {24'h0, 3'(s), 5'h0});
			repeat (40) @(posedge CORE_CLK);
			chk(32'(SYS_CLK_SEL), 32'(s - 1), "switch early");
			wait_sel(3'(s), (35 << (s - 1)) + 30);
		end
		// slow oscillator held unready: switch must not finish
		bus(1'b1, `SMC_OFS_SYS_CLK_CTRL, 32'hE0);
		repeat (1900) @(posedge CORE_CLK);
		chk(32'(SYS_CLK_SEL), 32'h6, "slow needs ls ready");
		LS_OSC_READY <= 1'b1;
		wait_sel(3'h7, 30);
		bus(1'b1, `SMC_OFS_HS_OSC_CTRL, 32'h0);
		for (int n = 0; n < 10 && HS_OSC_ON !== 1'b0; n++) @(posedge CORE_CLK);
		chk(32'(HS_OSC_ON), 32'h0, "slow follows enable");
		HS_OSC_READY <= 1'b0;
		// stopped oscillator: let its ready drop through the synchroniser first
		repeat (5) @(posedge CORE_CLK);
		bus(1'b1, `SMC_OFS_HS_OSC_CTRL, 32'h1);
		bus(1'b0, `SMC_OFS_HS_OSC_CTRL, 32'h0);
		chk(rd, 32'h1, "flag low on enable");
		HS_OSC_READY <= 1'b1;
		for (int n = 0; n < 10 && rd !== 32'h3; n++) bus(1'b0, `SMC_OFS_HS_OSC_CTRL, 32'h0);
		chk(rd, 32'h3, "flag high once stable");
		bus(1'b1, `SMC_OFS_SYS_CLK_CTRL, 32'h0);
		repeat (100) @(posedge CORE_CLK);
		chk(32'(SYS_CLK_SEL), 32'h7, "return early");
		wait_sel(3'h0, 40);
		$display("test clock switch done");
		finish_test();
	end
endmodule : smc_top_tb
